// [common/fbg_pkg.sv]
package fbg_pkg;

  // Number of serial channels, each with its own rate generator.
  localparam int NUM_CHANNELS = 2;

  // Register indices on the 3-bit register address.
  localparam logic [2:0] REG_DIV_LOW = 3'h0;
  localparam logic [2:0] REG_DIV_HIGH = 3'h1;
  localparam logic [2:0] REG_DIV_FRACTION = 3'h2;
  localparam logic [2:0] REG_MODEM_CONTROL = 3'h4;
  localparam logic [2:0] REG_ENHANCED_MODE = 3'h5;

  // Reset values.
  localparam logic [7:0] DIV_LOW_RESET = 8'h01;
  localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
  localparam logic [7:0] DIV_FRACTION_RESET = 8'h00;
  localparam logic [7:0] MODEM_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ENHANCED_MODE_RESET = 8'h00;

  // Field positions and widths.
  localparam int PRESCALE_SEL_BIT = 7;
  localparam int SAMPLE_X16_BIT = 7;
  localparam int FRACTION_WIDTH = 4;
  localparam int INTEGER_WIDTH = 16;

  // Division and sampling counts.
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [4:0] SAMPLES_PER_BIT_X16 = 5'h10;
  localparam logic [4:0] SAMPLES_PER_BIT_X8 = 5'h08;

  // System clock rate.
  localparam int SYS_CLK_HZ = 10_000_000;

endpackage

// [rtl/fbg_frac_divider.sv]
module fbg_frac_divider
  import fbg_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Divisor
  input wire logic i_restart,
  input wire logic [INTEGER_WIDTH-1:0] i_integer,
  input wire logic [FRACTION_WIDTH-1:0] i_fraction,
  // Prescaled edges in, sampling enable out
  input wire logic i_tick,
  output logic o_sample
);

  logic [INTEGER_WIDTH:0] count_q;
  logic [FRACTION_WIDTH-1:0] accum_q;
  logic sample_q;
  logic [FRACTION_WIDTH:0] accum_sum;
  logic [INTEGER_WIDTH:0] period_len;

  // An integer part of zero is treated as one so the generator never stalls.
  always_comb
  begin
    accum_sum = {1'b0, accum_q} + {1'b0, i_fraction};
    if (i_integer == '0)
    begin
      period_len = {{INTEGER_WIDTH{1'b0}}, 1'b1};
    end
    else
    begin
      period_len = {1'b0, i_integer};
    end
    // A carry out of the accumulator stretches this period by one prescaled input clock.
    period_len = period_len + {{INTEGER_WIDTH{1'b0}}, accum_sum[FRACTION_WIDTH]};
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || i_restart)
    begin
      count_q <= '0;
      accum_q <= '0;
      sample_q <= 1'b0;
    end
    else
    begin
      sample_q <= 1'b0;
      if (i_tick)
      begin
        if (count_q == period_len - {{INTEGER_WIDTH{1'b0}}, 1'b1})
        begin
          count_q <= '0;
          accum_q <= accum_sum[FRACTION_WIDTH-1:0];
          sample_q <= 1'b1;
        end
        else
        begin
          count_q <= count_q + {{INTEGER_WIDTH{1'b0}}, 1'b1};
        end
      end
    end
  end

  assign o_sample = sample_q;

endmodule

// [rtl/fbg_prescaler.sv]
module fbg_prescaler
  import fbg_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_restart,
  input wire logic i_div4,
  // Input clock edges and prescaled edges
  input wire logic i_tick,
  output logic o_tick
);

  logic [1:0] count_q;
  logic tick_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst || i_restart)
    begin
      count_q <= 2'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (i_tick)
      begin
        if (!i_div4)
        begin
          tick_q <= 1'b1;
        end
        else if (count_q == PRESCALE_LAST)
        begin
          count_q <= 2'h0;
          tick_q <= 1'b1;
        end
        else
        begin
          count_q <= count_q + 2'h1;
        end
      end
    end
  end

  assign o_tick = tick_q;

endmodule

// [rtl/fbg_top.sv]
module fbg_top
  import fbg_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h5C, // Arbitrary identification value.
  parameter logic [7:0] DEVICE_REV = 8'h03 // Arbitrary revision value.
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Oscillator pins
  input wire logic i_clock_input_pin,
  output logic o_oscillator_output_pin,
  // Register port
  input wire logic [NUM_CHANNELS-1:0] i_reg_sel,
  input wire logic [2:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Per-channel timing outputs
  output logic [NUM_CHANNELS-1:0] o_sample_tick,
  output logic [NUM_CHANNELS-1:0] o_bit_tick,
  output logic [NUM_CHANNELS-1:0] o_sample_x16,
  output logic [NUM_CHANNELS-1:0] o_prescale_div4
);

  // Writes to these indices change the divisor and so restart the chain.
  function automatic logic is_divisor_reg(input logic [2:0] addr);
    is_divisor_reg = (addr == REG_DIV_LOW) || (addr == REG_DIV_HIGH) ||
                     (addr == REG_DIV_FRACTION);
  endfunction

  // The pin clock is foreign to the system clock and must be synchronised
  // before its rising edges are counted. It must run below half the system rate.
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic pin_edge;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= i_clock_input_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // The input clock's rising edges drive only the rate generators below.
  assign pin_edge = pin_sync_q && !pin_prev_q;

  // The oscillator output is the inverted input, as a crystal amplifier drives it.
  logic osc_out_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      osc_out_q <= 1'b0;
    end
    else
    begin
      osc_out_q <= !pin_sync_q;
    end
  end

  assign o_oscillator_output_pin = osc_out_q;

  // Per-channel register file and timing chain.
  // Only the four implemented fraction bits are stored; the upper ones cannot be
  // written and always read back as zero.
  logic [7:0] div_low_q [NUM_CHANNELS];
  logic [7:0] div_high_q [NUM_CHANNELS];
  logic [3:0] div_fraction_q [NUM_CHANNELS];
  logic [7:0] modem_control_q [NUM_CHANNELS];
  logic [7:0] enhanced_mode_q [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0] restart_div;
  logic [NUM_CHANNELS-1:0] restart_pre;
  logic [NUM_CHANNELS-1:0] pre_tick;
  logic [NUM_CHANNELS-1:0] sample_tick;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch = ch + 1)
    begin : g_channel
      logic wr_here;
      logic [4:0] bit_count_q;
      logic bit_tick_q;
      logic [4:0] samples_per_bit;

      // Both channels may be selected together for a common write.
      assign wr_here = i_reg_wr && i_reg_sel[ch];

      always_ff @(posedge i_sys_clk)
      begin
        if (i_sys_rst)
        begin
          div_low_q[ch] <= DIV_LOW_RESET;
          div_high_q[ch] <= DIV_HIGH_RESET;
          div_fraction_q[ch] <= DIV_FRACTION_RESET[FRACTION_WIDTH-1:0];
        end
        else if (wr_here)
        begin
          if (i_reg_addr == REG_DIV_LOW)
          begin
            div_low_q[ch] <= i_reg_wdata;
          end
          else if (i_reg_addr == REG_DIV_HIGH)
          begin
            div_high_q[ch] <= i_reg_wdata;
          end
          else if (i_reg_addr == REG_DIV_FRACTION)
          begin
            div_fraction_q[ch] <= i_reg_wdata[FRACTION_WIDTH-1:0];
          end
        end
      end

      // Only bit 7 of each control register acts here; other bits are kept for readback.
      always_ff @(posedge i_sys_clk)
      begin
        if (i_sys_rst)
        begin
          modem_control_q[ch] <= MODEM_CONTROL_RESET;
          enhanced_mode_q[ch] <= ENHANCED_MODE_RESET;
        end
        else if (wr_here)
        begin
          if (i_reg_addr == REG_MODEM_CONTROL)
          begin
            modem_control_q[ch] <= i_reg_wdata;
          end
          else if (i_reg_addr == REG_ENHANCED_MODE)
          begin
            enhanced_mode_q[ch] <= i_reg_wdata;
          end
        end
      end

      // A divisor write restarts the whole chain so no period mixes divisors.
      // A prescale change restarts it too; otherwise the first period after the
      // change would be counted partly at the old input rate.
      assign restart_div[ch] = wr_here && is_divisor_reg(i_reg_addr);
      assign restart_pre[ch] = restart_div[ch] ||
                               (wr_here && (i_reg_addr == REG_MODEM_CONTROL));

      // Each channel divides the shared pin edges with its own prescale setting.
      fbg_prescaler u_prescaler (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_restart(restart_pre[ch]),
        .i_div4(modem_control_q[ch][PRESCALE_SEL_BIT]),
        .i_tick(pin_edge),
        .o_tick(pre_tick[ch])
      );

      // The divider shares the prescaler's restart so both begin a period together.
      fbg_frac_divider u_divider (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_restart(restart_pre[ch]),
        .i_integer({div_high_q[ch], div_low_q[ch]}),
        .i_fraction(div_fraction_q[ch]),
        .i_tick(pre_tick[ch]),
        .o_sample(sample_tick[ch])
      );

      // In 8X mode an odd fraction lands its stretch on alternate bits only,
      // so individual bit times may jitter by one prescaled input clock.
      assign samples_per_bit = enhanced_mode_q[ch][SAMPLE_X16_BIT] ?
                               SAMPLES_PER_BIT_X16 : SAMPLES_PER_BIT_X8;

      always_ff @(posedge i_sys_clk)
      begin
        if (i_sys_rst || restart_pre[ch])
        begin
          bit_count_q <= 5'h00;
          bit_tick_q <= 1'b0;
        end
        else
        begin
          bit_tick_q <= 1'b0;
          if (sample_tick[ch])
          begin
            // Comparing with >= lets a switch from 16X to 8X in mid-bit end that
            // bit at once instead of running the count through its full range.
            if (bit_count_q >= samples_per_bit - 5'h01)
            begin
              bit_count_q <= 5'h00;
              bit_tick_q <= 1'b1;
            end
            else
            begin
              bit_count_q <= bit_count_q + 5'h01;
            end
          end
        end
      end

      // The mode bits leave the block as levels for the transmitter and receiver.
      assign o_sample_tick[ch] = sample_tick[ch];
      assign o_bit_tick[ch] = bit_tick_q;
      assign o_sample_x16[ch] = enhanced_mode_q[ch][SAMPLE_X16_BIT];
      assign o_prescale_div4[ch] = modem_control_q[ch][PRESCALE_SEL_BIT];
    end
  endgenerate

  // Read path; the lowest selected channel answers when several are selected.
  // Reading both channels at once has no use, but the result stays defined.
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [7:0] rd_mux;
  logic id_mode;
  int rd_ch;

  always_comb
  begin
    rd_ch = 0;
    for (int i = NUM_CHANNELS - 1; i >= 0; i--)
    begin
      if (i_reg_sel[i])
      begin
        rd_ch = i;
      end
    end
    // With both divisor bytes zero the generator runs at a divisor of one, and the
    // two bytes read back the identification values instead.
    id_mode = (div_low_q[rd_ch] == 8'h00) && (div_high_q[rd_ch] == 8'h00);
    if (i_reg_addr == REG_DIV_LOW)
    begin
      rd_mux = id_mode ? DEVICE_REV : div_low_q[rd_ch];
    end
    else if (i_reg_addr == REG_DIV_HIGH)
    begin
      rd_mux = id_mode ? DEVICE_ID : div_high_q[rd_ch];
    end
    else if (i_reg_addr == REG_DIV_FRACTION)
    begin
      // Upper fraction bits are not implemented and read as zero.
      rd_mux = {4'h0, div_fraction_q[rd_ch]};
    end
    else if (i_reg_addr == REG_MODEM_CONTROL)
    begin
      rd_mux = modem_control_q[rd_ch];
    end
    else if (i_reg_addr == REG_ENHANCED_MODE)
    begin
      rd_mux = enhanced_mode_q[rd_ch];
    end
    else
    begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      // A read with no channel selected is ignored, so it gets no answer either.
      rvalid_q <= i_reg_rd && (i_reg_sel != '0);
      if (i_reg_rd && (i_reg_sel != '0))
      begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Read data holds until the next answered read.
  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;

endmodule

// [verif/fbg_osc_model.sv]
module fbg_osc_model
#(
  parameter int HALF = 3
)
(
  input wire logic i_sys_clk,
  input wire logic i_run,
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  initial
  begin
    o_pin = 1'b0;
    cnt = 0;
  end
  // The pin stands low while stopped so no stray edge reaches the prescaler.
  always @(negedge i_sys_clk)
  begin
    cnt = (!i_run || cnt == HALF - 1) ? 0 : cnt + 1;
    o_pin <= !i_run ? 1'b0 : (cnt == 0 ? !o_pin : o_pin);
  end
endmodule

// [verif/fbg_top_properties.sv]
module fbg_top_properties
  import fbg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [NUM_CHANNELS-1:0] i_reg_sel,
  input wire logic [2:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic [NUM_CHANNELS-1:0] o_sample_tick,
  input wire logic [NUM_CHANNELS-1:0] o_bit_tick,
  input wire logic [NUM_CHANNELS-1:0] o_sample_x16,
  input wire logic [NUM_CHANNELS-1:0] o_prescale_div4
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_read_answered: assert property (i_reg_rd && |i_reg_sel |=> o_reg_rvalid)
    else $error("read got no answer");
  a_no_stray_rvalid: assert property (!(i_reg_rd && |i_reg_sel) |=> !o_reg_rvalid)
    else $error("answer without a read");
  a_prescale_follows: assert property (i_reg_wr && i_reg_sel[0] &&
    i_reg_addr == REG_MODEM_CONTROL |=> o_prescale_div4[0] == $past(i_reg_wdata[7]))
    else $error("prescale select not updated");
  a_x16_follows: assert property (i_reg_wr && i_reg_sel[1] &&
    i_reg_addr == REG_ENHANCED_MODE |=> o_sample_x16[1] == $past(i_reg_wdata[7]))
    else $error("sampling mode not updated");
  a_chan_isolated: assert property (i_reg_wr && !i_reg_sel[1] |=>
    $stable(o_sample_x16[1]) && $stable(o_prescale_div4[1]))
    else $error("channel B changed by a write to A");
  a_sample_pulse: assert property (o_sample_tick[0] |=> !o_sample_tick[0])
    else $error("sample tick longer than one cycle");
  a_bit_after_sample: assert property (o_bit_tick[0] |-> $past(o_sample_tick[0]))
    else $error("bit tick not after a sample tick");
  a_restart_quiet: assert property (i_reg_wr && i_reg_sel[0] &&
    i_reg_addr <= REG_DIV_FRACTION |=> !o_sample_tick[0] [*2])
    else $error("sample tick right after divisor write");
  a_frac_upper_zero: assert property (o_reg_rvalid &&
    $past(i_reg_addr) == REG_DIV_FRACTION |-> o_reg_rdata[7:4] == 4'h0)
    else $error("fraction upper bits not zero");
endmodule

// [verif/fbg_top_tb_top.sv]
module fbg_top_tb_top
  import fbg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, pin, run, wr, rd, rvalid, osc_out;
  logic [1:0] sel, sample, bit_t, x16, div4;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, got;
  int n_errors, tests_run, cyc, smp;
  // Register rows: index, written value, value read back.
  logic [23:0] rows [6] = '{24'h00_0303, 24'h01_0000, 24'h02_F404, 24'h03_5500,
    24'h04_7F7F, 24'h05_0000};
  localparam logic [7:0] ID_CODE = 8'h5C; // Arbitrary value.
  localparam logic [7:0] REV_CODE = 8'h03; // Arbitrary value.

  fbg_top #(.DEVICE_ID(ID_CODE), .DEVICE_REV(REV_CODE)) dut_u (.i_sys_clk(clk),
    .i_sys_rst(rst), .i_clock_input_pin(pin),
    .o_oscillator_output_pin(osc_out), .i_reg_sel(sel), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_sample_tick(sample), .o_bit_tick(bit_t), .o_sample_x16(x16), .o_prescale_div4(div4));
  fbg_osc_model #(.HALF(3)) osc_u (.i_sys_clk(clk), .i_run(run), .o_pin(pin));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chkn(input string what, input int exp, input int seen);
    tests_run++;
    if (seen != exp)
    begin
      n_errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [1:0] s, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    sel = s;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [1:0] s, input logic [2:0] a, output logic [7:0] d);
    int k;
    @(negedge clk);
    sel = s;
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    for (k = 0; k < 4 && rvalid !== 1'b1; k++)
      @(negedge clk);
    d = rdata;
    if (k == 4)
    begin
      n_errors++;
      end_of_test();
    end
  endtask

  // Waits for one event, then counts cycles and sample ticks over n more events.
  task automatic count_ticks(input int ch, input bit use_bit, input int n);
    int seen;
    seen = 0;
    cyc = 0;
    smp = 0;
    while ((use_bit ? bit_t[ch] : sample[ch]) !== 1'b1 && cyc < 30000)
      @(negedge clk) cyc++;
    cyc = 0;
    while (seen < n && cyc < 30000)
    begin
      @(negedge clk);
      cyc++;
      smp += (sample[ch] === 1'b1);
      seen += ((use_bit ? bit_t[ch] : sample[ch]) === 1'b1);
    end
    if (seen < n)
    begin
      n_errors++;
      end_of_test();
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    {rst, run, wr, rd, sel, addr, wdata, n_errors, tests_run} = '0;
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    chk8("modes", 8'h00, {4'h0, x16, div4});
    for (int a = 0; a < 3; a++)
    begin
      rd_reg(2'b01, a[2:0], got);
      chk8("reset divisor", a == 0 ? 8'h01 : 8'h00, got);
    end
    run = 1'b1;
    for (int ch = 0; ch < 2; ch++)
    begin
      count_ticks(ch, 1'b0, 16);
      chkn("unit divisor span", 96, cyc);
    end
    count_ticks(0, 1'b1, 1);
    chkn("8x samples per bit", 8, smp);
    foreach (rows[i])
    begin
      wr_reg(2'b01, rows[i][18:16], rows[i][15:8]);
      rd_reg(2'b01, rows[i][18:16], got);
      chk8("readback", rows[i][7:0], got);
    end
    count_ticks(0, 1'b0, 16);
    chkn("divisor 3.25 span", 52 * 6, cyc);
    wr_reg(2'b01, REG_MODEM_CONTROL, 8'h80);
    chk8("prescale out", 8'h01, {6'h00, div4});
    count_ticks(0, 1'b0, 16);
    chkn("div4 span", 52 * 24, cyc);
    wr_reg(2'b01, REG_ENHANCED_MODE, 8'h80);
    count_ticks(0, 1'b1, 1);
    chkn("16x samples per bit", 16, smp);
    wr_reg(2'b01, REG_MODEM_CONTROL, 8'h00);
    wr_reg(2'b01, REG_DIV_FRACTION, 8'h00);
    wr_reg(2'b01, REG_DIV_LOW, 8'h00);
    rd_reg(2'b01, REG_DIV_HIGH, got);
    chk8("id code", ID_CODE, got);
    rd_reg(2'b01, REG_DIV_LOW, got);
    chk8("rev code", REV_CODE, got);
    wr_reg(2'b01, REG_DIV_HIGH, 8'h01);
    count_ticks(0, 1'b0, 1);
    chkn("high byte span", 256 * 6, cyc);
    wr_reg(2'b11, REG_ENHANCED_MODE, 8'h80);
    chk8("both selected", 8'h03, {6'h00, x16});
    wr_reg(2'b10, REG_ENHANCED_MODE, 8'h00);
    chk8("b only", 8'h01, {6'h00, x16});
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk8("outputs in reset", 8'h00, {sample, bit_t, x16, div4});
    chk8("port in reset", 8'h00, {6'h00, osc_out, rvalid});
    rst = 1'b0;
    for (int a = 0; a < 3; a++)
    begin
      rd_reg(2'b01, a[2:0], got);
      chk8("divisor after reset", a == 0 ? 8'h01 : 8'h00, got);
    end
    count_ticks(0, 1'b0, 16);
    chkn("span after reset", 96, cyc);
    run = 1'b0;
    repeat (8) @(negedge clk);
    chk8("osc out idle", 8'h01, {7'h00, osc_out});
    end_of_test();
  end
endmodule

bind fbg_top fbg_top_properties chk_u (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
  .i_reg_sel(i_reg_sel), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
  .o_sample_tick(o_sample_tick), .o_bit_tick(o_bit_tick), .o_sample_x16(o_sample_x16),
  .o_prescale_div4(o_prescale_div4));
